// *** compare_skip_decimal_adjust_tb_top.sv ***
module compare_skip_decimal_adjust_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csd_pkg::*;

	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic        psel      = 1'b0;
	logic        pen       = 1'b0;
	logic        pwr       = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  phase;
	logic        busy;
	logic        skip;
	int          n_errors  = 0;
	int          cmp_count = 0;
	int          busy_cnt  = 0;
	int          skip_cnt  = 0;
	int          run       = 0;

	always #12.5 clk = ~clk;

	csd_core dut (
		.core_clk_in (clk),
		.rst_n_in    (rst_n),
		.psel_in     (psel),
		.penable_in  (pen),
		.pwrite_in   (pwr),
		.paddr_in    (paddr),
		.pwdata_in   (pwdata),
		.prdata_out  (prdata),
		.pready_out  (pready),
		.pslverr_out (pslverr),
		.phase_out   (phase),
		.busy_out    (busy),
		.skip_out    (skip)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd  = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic        e;
		apb(1'b1, a, d, v, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic e;
		apb(1'b0, a, 32'h0, v, e);
	endtask : rd

	task automatic mem_wr(input logic [11:0] ad, input logic [7:0] v);
		wr(OFS_MADDR, {20'h0, ad});
		wr(OFS_MDATA, {24'h0, v});
	endtask : mem_wr

	// run one instruction, then judge its length and skip cycles
	task automatic exec(input logic [16:0] w, input int cyc);
		logic [31:0] x;
		int          b0;
		int          s0;
		int          n;
		b0 = busy_cnt;
		s0 = skip_cnt;
		wr(OFS_INSTR, {15'h0, w});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((n < 2 || busy !== 1'b0) && n < 40);
		if (busy !== 1'b0) begin
			n_errors++;
			end_of_test();
		end
		rd(OFS_EXEC, x);
		chk(x[3:0], {cyc[1:0], cyc > 1, 1'b0});
		chk(busy_cnt - b0, 4 * cyc);
		chk(skip_cnt - s0, 4 * cyc - 4);
	endtask : exec

	// phase order and idle skip cycles while busy
	always @(posedge clk) begin
		if (busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
			run <= run + 1;
			if (skip === 1'b1) begin
				skip_cnt <= skip_cnt + 1;
			end
			chk({30'h0, phase}, run % 4);
			chk({31'h0, skip}, {31'h0, run >= 4});
		end else begin
			run <= 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input int op, input logic [7:0] w, input logic [7:0] m,
		input logic two, input logic sk);
		logic [15:0] word;
		logic [31:0] v;
		logic        e;
		word = (op == 0) ? 16'h3633 : (op == 1) ? 16'h6533 : 16'h6133;
		wr(OFS_WORK, {24'h0, w});
		mem_wr(12'h233, m);
		wr(OFS_STATUS, 32'h17);
		exec({two, word}, sk ? (two ? 3 : 2) : 1);
		rd(OFS_WORK, v);
		chk(v, {24'h0, w});
		rd(OFS_STATUS, v);
		chk(v, 32'h17);
		rd(OFS_MDATA, v);
		chk(v, {24'h0, m});
		apb(1'b0, 8'h24, 32'h0, v, e);
		chk({31'h0, e}, 32'h1);
	endtask : cmp

	task automatic t_cmp();
		wr(OFS_BANK, 32'h2);
		cmp(0, 8'h5a, 8'h5a, 1'b0, 1'b1);
		cmp(0, 8'h5a, 8'h5b, 1'b0, 1'b0);
		cmp(0, 8'h00, 8'h00, 1'b1, 1'b1);
		cmp(1, 8'hfe, 8'hff, 1'b0, 1'b1);
		cmp(1, 8'h80, 8'h80, 1'b0, 1'b0);
		cmp(1, 8'hff, 8'h01, 1'b1, 1'b0);
		cmp(2, 8'h01, 8'h00, 1'b1, 1'b1);
		cmp(2, 8'h01, 8'hff, 1'b0, 1'b0);
		cmp(2, 8'h7f, 8'h7f, 1'b0, 1'b0);
	endtask : t_cmp

	task automatic cpl(input logic a, input logic d, input logic ext,
		input logic [7:0] f, input logic [11:0] ad);
		logic [31:0] v;
		wr(OFS_CTRL, {31'h0, ext});
		mem_wr(ad, 8'h13);
		wr(OFS_WORK, 32'ha0);
		exec({1'b0, 6'h07, d, a, f}, 1);
		rd(OFS_MDATA, v);
		chk(v, d ? 32'hec : 32'h13);
		rd(OFS_WORK, v);
		chk(v, d ? 32'ha0 : 32'hec);
	endtask : cpl

	task automatic t_cpl();
		wr(OFS_BANK, 32'h2);
		wr(OFS_INDEX, 32'h500);
		cpl(1'b1, 1'b1, 1'b0, 8'h44, 12'h244);
		cpl(1'b0, 1'b0, 1'b0, 8'h44, 12'h044);
		cpl(1'b0, 1'b1, 1'b0, 8'h90, 12'hf90);
		cpl(1'b0, 1'b1, 1'b1, 8'h5f, 12'h55f);
		cpl(1'b0, 1'b1, 1'b1, 8'h60, 12'h060);
		cpl(1'b1, 1'b1, 1'b1, 8'h20, 12'h220);
		wr(OFS_CTRL, 32'h0);
	endtask : t_cpl

	task automatic dadj(input logic [7:0] w, input logic c, input logic dc);
		logic [3:0]  lo;
		logic [4:0]  hi;
		logic [31:0] v;
		lo = (w[3:0] > 9 || dc) ? w[3:0] + 4'h6 : w[3:0];
		hi = (w[7:4] + dc > 9 || c) ? w[7:4] + 5'h6 + dc : w[7:4] + dc;
		wr(OFS_WORK, {24'h0, w});
		wr(OFS_STATUS, {30'h0, dc, c});
		exec(17'h00007, 1);
		rd(OFS_WORK, v);
		chk(v, {24'h0, hi[3:0], lo});
		rd(OFS_STATUS, v);
		chk(v, {30'h0, dc, c | hi[4]});
	endtask : dadj

	task automatic t_dadj();
		dadj(8'ha5, 1'b0, 1'b0);
		dadj(8'hce, 1'b0, 1'b0);
		dadj(8'h19, 1'b0, 1'b1);
		dadj(8'h45, 1'b1, 1'b0);
		dadj(8'h99, 1'b0, 1'b0);
		dadj(8'h9a, 1'b0, 1'b0);
	endtask : t_dadj

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_cmp();
		t_cpl();
		t_dadj();
		end_of_test();
	end

endmodule : compare_skip_decimal_adjust_tb_top

// *** csd_addr_gen.sv ***
module csd_addr_gen (
	input  wire  logic [7:0]  file_in,
	input  wire  logic        a_in,
	input  wire  logic        ext_en_in,
	input  wire  logic [3:0]  bank_in,
	input  wire  logic [11:0] index_in,
	output logic       [11:0] addr_out
);
	import csd_pkg::*;

	always_comb begin
		if (!a_in && ext_en_in && file_in <= INDEXED_MAX) begin
			addr_out = index_in + {4'h0, file_in};
		end else if (!a_in) begin
			// access bank: low half bank 0, high half the top bank
			addr_out = file_in[7] ? {ACCESS_HIGH_BANK, file_in}
				: {4'h0, file_in};
		end else begin
			addr_out = {bank_in, file_in};
		end
	end

endmodule : csd_addr_gen

// *** csd_alu.sv ***
module csd_alu (
	input  wire  csd_pkg::csd_op_t op_in,
	input  wire  logic [7:0]       operand_in,
	input  wire  logic [7:0]       work_in,
	input  wire  logic             c_in,
	input  wire  logic             dc_in,
	output logic       [7:0]       result_out,
	output logic                   c_out,
	output logic                   n_out,
	output logic                   z_out,
	output logic                   skip_out
);
	import csd_pkg::*;

	logic [8:0] diff;
	logic [3:0] lo;
	logic [4:0] hi;

	always_comb begin
		// unsigned subtraction only steers the skip
		diff = {1'b0, operand_in} - {1'b0, work_in};
		case (op_in)
			op_cmp_eq: skip_out = (diff == 9'h000);
			op_cmp_gt: skip_out = !diff[8] && diff != 9'h000;
			op_cmp_lt: skip_out = diff[8];
			default:   skip_out = 1'b0;
		endcase
		if (operand_in[3:0] > BCD_MAX || dc_in) begin
			lo = operand_in[3:0] + BCD_FIX;
		end else begin
			lo = operand_in[3:0];
		end
		hi = {1'b0, operand_in[7:4]} + {4'h0, dc_in};
		if (hi > {1'b0, BCD_MAX} || c_in) begin
			hi = hi + {1'b0, BCD_FIX};
		end
		result_out = 8'h00;
		c_out      = c_in;
		if (op_in == op_dadj) begin
			result_out = {hi[3:0], lo};
			c_out      = c_in | hi[4];
		end else if (op_in == op_cpl) begin
			result_out = ~operand_in;
		end
		n_out = result_out[7];
		z_out = (result_out == 8'h00);
	end

endmodule : csd_alu

// *** csd_core.sv ***
// Added by the designer: the APB interface to the registers and the address map.
module csd_core (
	input  wire  logic                      core_clk_in,
	input  wire  logic                      rst_n_in,
	input  wire  logic                      psel_in,
	input  wire  logic                      penable_in,
	input  wire  logic                      pwrite_in,
	input  wire  logic [csd_pkg::APB_AW-1:0] paddr_in,
	input  wire  logic [31:0]               pwdata_in,
	output logic       [31:0]               prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	output logic       [1:0]                phase_out,
	output logic                            busy_out,
	output logic                            skip_out
);
	import csd_pkg::*;

	typedef enum {st_idle, st_exec, st_skip} csd_state_t;

	csd_state_t  state_r;
	logic [1:0]  phase_r;
	logic [1:0]  skips_left_r;
	logic        busy_r;
	logic        skip_r;
	logic [15:0] instr_r;
	logic        two_word_r;
	csd_op_t     op_r;
	logic [11:0] addr_r;
	logic [7:0]  operand_r;
	logic [7:0]  result_r;
	logic        skip_pend_r;
	logic        c_res_r;
	logic        n_res_r;
	logic        z_res_r;
	logic        last_skip_r;
	logic [1:0]  last_cycles_r;
	logic [7:0]  work_r;
	logic [3:0]  bank_r;
	logic [4:0]  status_r;
	logic [11:0] index_r;
	logic        ext_en_r;
	logic [11:0] maddr_r;
	logic [7:0]  mem_r [MEM_BYTES];
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;

	logic [11:0] eff_addr;
	logic [7:0]  alu_result;
	logic        alu_c;
	logic        alu_n;
	logic        alu_z;
	logic        alu_skip;
	logic [31:0] rd_val;
	logic        rd_err;
	logic        bus_setup;
	logic        bus_wr;
	logic        start;
	logic        exec_q2;
	logic        exec_q3;
	logic        exec_q4;
	logic        mem_we;
	logic        work_we;
	logic        is_cmp;

	assign prdata_out  = prdata_r;
	assign pready_out  = pready_r;
	assign pslverr_out = pslverr_r;
	assign phase_out   = phase_r;
	assign busy_out    = busy_r;
	assign skip_out    = skip_r;

	////////////////////////////////////////////////////////////////////////
	// operand address and arithmetic
	csd_addr_gen u_addr (
		.file_in   (instr_r[7:0]),
		.a_in      (csd_a_bit(instr_r)),
		.ext_en_in (ext_en_r),
		.bank_in   (bank_r),
		.index_in  (index_r),
		.addr_out  (eff_addr)
	);

	csd_alu u_alu (
		.op_in      (op_r),
		.operand_in (operand_r),
		.work_in    (work_r),
		.c_in       (status_r[ST_C_BIT]),
		.dc_in      (status_r[ST_DC_BIT]),
		.result_out (alu_result),
		.c_out      (alu_c),
		.n_out      (alu_n),
		.z_out      (alu_z),
		.skip_out   (alu_skip)
	);

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign bus_setup = psel_in && !penable_in;
	assign bus_wr    = psel_in && penable_in && pready_r && pwrite_in
		&& !pslverr_r;
	assign start     = bus_wr && paddr_in == OFS_INSTR;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr_in)
			OFS_CTRL:   rd_val[CTRL_EXT_BIT] = ext_en_r;
			OFS_INSTR:  rd_val[16:0] = {two_word_r, instr_r};
			OFS_WORK:   rd_val[7:0] = work_r;
			OFS_BANK:   rd_val[3:0] = bank_r;
			OFS_STATUS: rd_val[4:0] = status_r;
			OFS_INDEX:  rd_val[11:0] = index_r;
			OFS_MADDR:  rd_val[11:0] = maddr_r;
			OFS_MDATA:  rd_val[7:0] = mem_r[maddr_r];
			OFS_EXEC: begin
				rd_val[EXEC_BUSY_BIT] = busy_r;
				rd_val[EXEC_SKIP_BIT] = last_skip_r;
				rd_val[EXEC_CYC_LSB +: 2] = last_cycles_r;
				rd_err = pwrite_in;
			end
			default:    rd_err = 1'b1;
		endcase
		// core state other than the control register is locked while an instruction runs
		if (pwrite_in && busy_r && paddr_in != OFS_CTRL) begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= bus_setup;
			pslverr_r <= bus_setup && rd_err;
			prdata_r  <= (bus_setup && !pwrite_in && !rd_err) ? rd_val
				: 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// instruction sequencer, one clock per phase
	assign exec_q2 = state_r == st_exec && phase_r == 2'd1;
	assign exec_q3 = state_r == st_exec && phase_r == 2'd2;
	assign exec_q4 = state_r == st_exec && phase_r == 2'd3;
	assign is_cmp  = op_r == op_cmp_eq || op_r == op_cmp_gt
		|| op_r == op_cmp_lt;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_r       <= st_idle;
			phase_r       <= 2'd0;
			skips_left_r  <= 2'd0;
			busy_r        <= 1'b0;
			skip_r        <= 1'b0;
			last_skip_r   <= 1'b0;
			last_cycles_r <= 2'd0;
		end else begin
			case (state_r)
				st_idle: begin
					phase_r <= 2'd0;
					if (start) begin
						state_r <= st_exec;
						busy_r  <= 1'b1;
					end
				end
				st_exec: begin
					phase_r <= phase_r + 2'd1;
					if (phase_r == 2'd3) begin
						last_skip_r <= skip_pend_r;
						if (skip_pend_r) begin
							state_r       <= st_skip;
							skip_r        <= 1'b1;
							skips_left_r  <= two_word_r ? 2'd2 : 2'd1;
							last_cycles_r <= two_word_r ? 2'd3 : 2'd2;
						end else begin
							state_r       <= st_idle;
							busy_r        <= 1'b0;
							last_cycles_r <= 2'd1;
						end
					end
				end
				st_skip: begin
					phase_r <= phase_r + 2'd1;
					if (phase_r == 2'd3) begin
						skips_left_r <= skips_left_r - 2'd1;
						if (skips_left_r == 2'd1) begin
							state_r <= st_idle;
							busy_r  <= 1'b0;
							skip_r  <= 1'b0;
						end
					end
				end
				default: begin
					state_r <= st_idle;
					busy_r  <= 1'b0;
					skip_r  <= 1'b0;
				end
			endcase
		end
	end

	// q1 decode, q2 read, q3 process
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			instr_r     <= 16'h0000;
			two_word_r  <= 1'b0;
			op_r        <= op_none;
			addr_r      <= 12'h000;
			operand_r   <= 8'h00;
			result_r    <= 8'h00;
			skip_pend_r <= 1'b0;
			c_res_r     <= 1'b0;
			n_res_r     <= 1'b0;
			z_res_r     <= 1'b0;
		end else begin
			if (start) begin
				instr_r    <= pwdata_in[15:0];
				two_word_r <= pwdata_in[INSTR_TWO_BIT];
			end
			if (state_r == st_exec && phase_r == 2'd0) begin
				op_r   <= csd_decode(instr_r);
				addr_r <= eff_addr;
			end
			if (exec_q2) begin
				operand_r <= (op_r == op_dadj) ? work_r : mem_r[addr_r];
			end
			if (exec_q3) begin
				result_r    <= alu_result;
				skip_pend_r <= alu_skip;
				c_res_r     <= alu_c;
				n_res_r     <= alu_n;
				z_res_r     <= alu_z;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// q4 write back and software registers
	assign work_we = exec_q4 && (op_r == op_dadj
		|| (op_r == op_cpl && !instr_r[CPL_D_BIT]));
	assign mem_we  = exec_q4 && op_r == op_cpl && instr_r[CPL_D_BIT];

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			work_r <= RST_WORK;
		end else if (work_we) begin
			work_r <= result_r;
		end else if (bus_wr && paddr_in == OFS_WORK) begin
			work_r <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			status_r <= RST_STATUS;
		end else if (exec_q4 && op_r == op_dadj) begin
			status_r[ST_C_BIT] <= c_res_r;
		end else if (exec_q4 && op_r == op_cpl) begin
			status_r[ST_N_BIT] <= n_res_r;
			status_r[ST_Z_BIT] <= z_res_r;
		end else if (bus_wr && paddr_in == OFS_STATUS) begin
			status_r <= pwdata_in[4:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (mem_we) begin
			mem_r[addr_r] <= result_r;
		end else if (bus_wr && paddr_in == OFS_MDATA) begin
			mem_r[maddr_r] <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			bank_r   <= RST_BANK;
			index_r  <= RST_INDEX;
			maddr_r  <= 12'h000;
			ext_en_r <= 1'b0;
		end else if (bus_wr) begin
			case (paddr_in)
				OFS_BANK:  bank_r   <= pwdata_in[3:0];
				OFS_INDEX: index_r  <= pwdata_in[11:0];
				OFS_MADDR: maddr_r  <= pwdata_in[11:0];
				OFS_CTRL:  ext_en_r <= pwdata_in[CTRL_EXT_BIT];
				default:   ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_skip_cycle;
		(skip_r && busy_r) [*4];
	endsequence

	sequence s_end_skip_one;
		exec_q4 && skip_pend_r && !two_word_r;
	endsequence

	sequence s_end_skip_two;
		exec_q4 && skip_pend_r && two_word_r;
	endsequence

	a_eq_skip: assert property (exec_q3 && op_r == op_cmp_eq |=>
		skip_pend_r == (operand_r == work_r))
		else $error("equal compare skip decision wrong");
	a_gt_skip: assert property (exec_q3 && op_r == op_cmp_gt |=>
		skip_pend_r == (operand_r > work_r))
		else $error("greater compare skip decision wrong");
	a_lt_skip: assert property (exec_q3 && op_r == op_cmp_lt |=>
		skip_pend_r == (operand_r < work_r))
		else $error("less compare skip decision wrong");
	a_cmp_quiet: assert property (state_r == st_exec && is_cmp |->
		!mem_we ##1 ($stable(status_r) && $stable(work_r)))
		else $error("compare changed state");
	a_skip_one: assert property (s_end_skip_one |=>
		s_skip_cycle ##1 !busy_r)
		else $error("one-word skip length wrong");
	a_skip_two: assert property (s_end_skip_two |=>
		s_skip_cycle ##1 s_skip_cycle ##1 !busy_r)
		else $error("two-word skip length wrong");
	a_no_skip: assert property (exec_q4 && !skip_pend_r |=>
		!busy_r && !skip_r)
		else $error("compare without skip overran");
	a_phase_walk: assert property (start |=>
		phase_r == 2'd0 ##1 phase_r == 2'd1 ##1 phase_r == 2'd2
		##1 phase_r == 2'd3)
		else $error("phase order wrong");
	a_skip_idle: assert property (skip_r |-> !mem_we && !work_we)
		else $error("skip cycle did work");
	a_bank_select: assert property (state_r == st_exec
		&& csd_a_bit(instr_r) |-> eff_addr == {bank_r, instr_r[7:0]})
		else $error("bank select address wrong");
	a_indexed_addr: assert property (state_r == st_exec
		&& !csd_a_bit(instr_r) && ext_en_r && instr_r[7:0] <= INDEXED_MAX
		|-> eff_addr == index_r + {4'h0, instr_r[7:0]})
		else $error("indexed address wrong");
	a_dadj_low: assert property (exec_q4 && op_r == op_dadj |=>
		work_r[3:0] == (($past(operand_r[3:0]) > BCD_MAX
		|| status_r[ST_DC_BIT]) ? $past(operand_r[3:0]) + BCD_FIX
		: $past(operand_r[3:0])))
		else $error("decimal adjust low nibble wrong");
	a_dadj_high: assert property (exec_q4 && op_r == op_dadj
		&& !status_r[ST_C_BIT] && !status_r[ST_DC_BIT]
		&& operand_r[7:4] <= BCD_MAX |=> work_r[7:4] == $past(operand_r[7:4]))
		else $error("decimal adjust high nibble wrong");
	a_dadj_timing: assert property (state_r == st_exec
		&& op_r == op_dadj && phase_r != 2'd3 |=> $stable(work_r))
		else $error("decimal adjust wrote early");
	a_cpl_work: assert property (exec_q4 && op_r == op_cpl
		&& !instr_r[CPL_D_BIT] |=> work_r == ~operand_r)
		else $error("complement to working register wrong");
	a_cpl_mem: assert property (exec_q4 && op_r == op_cpl
		&& instr_r[CPL_D_BIT] |=> mem_r[addr_r] == ~operand_r)
		else $error("complement to byte wrong");

endmodule : csd_core

// *** csd_pkg.sv ***
package csd_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the apb bus
	localparam int         APB_AW     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_INSTR  = 8'h04;
	localparam logic [7:0] OFS_WORK   = 8'h08;
	localparam logic [7:0] OFS_BANK   = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_INDEX  = 8'h14;
	localparam logic [7:0] OFS_MADDR  = 8'h18;
	localparam logic [7:0] OFS_MDATA  = 8'h1c;
	localparam logic [7:0] OFS_EXEC   = 8'h20;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_EXT_BIT    = 0;
	localparam int INSTR_TWO_BIT   = 16;
	localparam int ST_C_BIT        = 0;
	localparam int ST_DC_BIT       = 1;
	localparam int ST_Z_BIT        = 2;
	localparam int ST_N_BIT        = 4;
	localparam int EXEC_BUSY_BIT   = 0;
	localparam int EXEC_SKIP_BIT   = 1;
	localparam int EXEC_CYC_LSB    = 2;
	localparam int CPL_D_BIT       = 9;
	localparam int EQ_A_BIT        = 12;
	localparam int STD_A_BIT       = 8;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0]  RST_WORK   = 8'h00;
	localparam logic [3:0]  RST_BANK   = 4'h0;
	localparam logic [4:0]  RST_STATUS = 5'h00;
	localparam logic [11:0] RST_INDEX  = 12'h000;

	////////////////////////////////////////////////////////////////////////
	// addressing and arithmetic constants
	localparam int         ADDR_W           = 12;
	localparam int         MEM_BYTES        = 4096;
	localparam logic [7:0] INDEXED_MAX      = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [3:0] BCD_MAX          = 4'h9;
	localparam logic [3:0] BCD_FIX          = 4'h6;

	////////////////////////////////////////////////////////////////////////
	// instruction encodings
	localparam logic [15:0] CMP_EQ_MASK = 16'hef00;
	localparam logic [15:0] CMP_EQ_VAL  = 16'h2600;
	localparam logic [15:0] CMP_GT_MASK = 16'hfe00;
	localparam logic [15:0] CMP_GT_VAL  = 16'h6400;
	localparam logic [15:0] CMP_LT_MASK = 16'hfe00;
	localparam logic [15:0] CMP_LT_VAL  = 16'h6000;
	localparam logic [15:0] DADJ_VAL    = 16'h0007;
	localparam logic [15:0] CPL_MASK    = 16'hfc00;
	localparam logic [15:0] CPL_VAL     = 16'h1c00;

	typedef enum logic [2:0] {
		op_none,
		op_cmp_eq,
		op_cmp_gt,
		op_cmp_lt,
		op_dadj,
		op_cpl
	} csd_op_t;

	function automatic csd_op_t csd_decode(input logic [15:0] w);
		if ((w & CMP_EQ_MASK) == CMP_EQ_VAL) return op_cmp_eq;
		if ((w & CMP_GT_MASK) == CMP_GT_VAL) return op_cmp_gt;
		if ((w & CMP_LT_MASK) == CMP_LT_VAL) return op_cmp_lt;
		if (w == DADJ_VAL) return op_dadj;
		if ((w & CPL_MASK) == CPL_VAL) return op_cpl;
		return op_none;
	endfunction : csd_decode

	// bank-select operand bit sits higher in the equal-compare word
	function automatic logic csd_a_bit(input logic [15:0] w);
		if (csd_decode(w) == op_cmp_eq) return w[EQ_A_BIT];
		return w[STD_A_BIT];
	endfunction : csd_a_bit

endpackage : csd_pkg
